/* include/flash_host_params.svh */
// constants, timing counts and register map of the flash host controller
// Operation
// - host loads each byte with a strobe pulse, other strobe low, read enable high.
// - under the guard the host loads all 128 bytes of the sector; a guarded write order here loads only its one data byte.
// - host activates a lockout with seven command writes.
// - host should leave identification mode with the exit sequence.
// - next byte load within 150 us, else the device starts programming.
// - address bits 7 to 16 pick the sector and stay fixed across its loads.
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

`define FL_CLK_NS        10
`define FL_T_WP_NS       90
`define FL_T_WPH_NS      100
`define FL_T_ACC_NS      150
`define FL_T_LOAD_US     150
`define FL_T_WC_MS       10
`define FL_T_PWR_MS      5
`define FL_WP_CYC        ((`FL_T_WP_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_WPH_CYC       ((`FL_T_WPH_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_RD_CYC        ((`FL_T_ACC_NS + `FL_CLK_NS - 1) / `FL_CLK_NS + 3)
`define FL_LOAD_CYC      (`FL_T_LOAD_US * 1000 / `FL_CLK_NS + 1)
`define FL_WC_CYC        (`FL_T_WC_MS * 1000000 / `FL_CLK_NS)
`define FL_PWR_CYC       (`FL_T_PWR_MS * 1000000 / `FL_CLK_NS)

`define FL_SECTOR_BYTES  128
`define FL_POS_CMD_END   8'h06
`define FL_POS_SHORT     8'h03
`define FL_LOCK_HI_SEL   0

`define FL_SEQ_ADR1      17'h05555
`define FL_SEQ_ADR2      17'h02aaa
`define FL_SEQ_DAT1      8'haa
`define FL_SEQ_DAT2      8'h55
`define FL_SEQ_LONG      8'h80
`define FL_CODE_GUARD    8'ha0
`define FL_CODE_UNGUARD  8'h20
`define FL_CODE_ERASE    8'h10
`define FL_CODE_ID_IN    8'h90
`define FL_CODE_ID_OUT   8'hf0
`define FL_CODE_LOCK     8'h40
`define FL_ADR_LOCK_LO   20'h00002
`define FL_ADR_LOCK_HI   20'hffff2
`define FL_LOCKED        8'hff

`define FL_REG_CTRL      10'h000
`define FL_REG_ADDR      10'h004
`define FL_REG_WDATA     10'h008
`define FL_REG_STAT      10'h00c
`define FL_BUF_BIT       9
`define FL_CTRL_GUARD    8

`endif

/* include/flash_host_pkg.sv */
// types shared by the flash host controller
package flash_host_pkg;
	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_SETUP   = 7'h02,
		ST_LOW     = 7'h04,
		ST_HIGH    = 7'h08,
		ST_ENDWAIT = 7'h10,
		ST_READ    = 7'h20,
		ST_RGAP    = 7'h40
	} state_type;

	typedef enum logic [3:0] {
		OP_NONE      = 4'h0,
		OP_READ      = 4'h1,
		OP_WRITE     = 4'h2,
		OP_PROGRAM   = 4'h3,
		OP_GUARD_ON  = 4'h4,
		OP_GUARD_OFF = 4'h5,
		OP_ERASE     = 4'h6,
		OP_ID_ENTER  = 4'h7,
		OP_ID_EXIT   = 4'h8,
		OP_LOCK      = 4'h9,
		OP_LOCK_STAT = 4'ha
	} op_type;
endpackage

/* include/strobe_if.sv */
// flash pin signals between sequencer and pin stage
`timescale 1ns/10ps
interface strobe_if;
	logic [16:0] adr;
	logic [7:0]  dout;
	logic        doe;
	logic        ce_n;
	logic        oe_n;
	logic        we_n;
	logic [7:0]  din;
	modport ctl (output adr, dout, doe, ce_n, oe_n, we_n, input din);
	modport pin (input adr, dout, doe, ce_n, oe_n, we_n, output din);
endinterface

/* hw/flash_pin_drv.sv */
// registered flash pin stage with read data synchroniser
`timescale 1ns/10ps
module flash_pin_drv (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// sequencer side
	strobe_if.pin            s,
	// flash pins
	output logic      [16:0] flash_adr_o,
	output logic             flash_ce_n_o,
	output logic             flash_oe_n_o,
	output logic             flash_we_n_o,
	output logic      [7:0]  flash_dat_o,
	output logic             flash_dat_oe_o,
	input  wire logic [7:0]  flash_dat_i
);
	logic [7:0] meta_r;
	logic [7:0] sync_r;

	// one register stage keeps every pin edge glitch free
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flash_ce_n_o   <= 1'b1;
			flash_oe_n_o   <= 1'b1;
			flash_we_n_o   <= 1'b1;
			flash_dat_oe_o <= 1'b0;
			flash_adr_o    <= 17'h00000;
			flash_dat_o    <= 8'h00;
		end else begin
			flash_ce_n_o   <= s.ce_n;
			flash_oe_n_o   <= s.oe_n;
			flash_we_n_o   <= s.we_n;
			flash_dat_oe_o <= s.doe;
			flash_adr_o    <= s.adr;
			flash_dat_o    <= s.dout;
		end
	end

	always_ff @(posedge clk_i) begin
		meta_r <= flash_dat_i;
		sync_r <= meta_r;
	end

	assign s.din = sync_r;
endmodule

/* hw/flash_host_ctl.sv */
// host-side sequencer driving a parallel sector flash, wishbone register port
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`include "flash_host_params.svh"
module flash_host_ctl #(
	parameter int unsigned LOAD_END_CYC = `FL_LOAD_CYC,
	parameter int unsigned WC_CYC       = `FL_WC_CYC,
	parameter int unsigned POWER_CYC    = `FL_PWR_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// flash pins
	output logic      [16:0] flash_adr_o,
	output logic             flash_ce_n_o,
	output logic             flash_oe_n_o,
	output logic             flash_we_n_o,
	output logic      [7:0]  flash_dat_o,
	output logic             flash_dat_oe_o,
	input  wire logic [7:0]  flash_dat_i
);
	strobe_if s ();

	flash_host_pkg::state_type st_r;
	flash_host_pkg::state_type st_nxt;
	flash_host_pkg::op_type    op_r;
	flash_host_pkg::op_type    op_new;
	logic [16:0] adr_r;
	logic [7:0]  wdat_r;
	logic        guard_r;
	logic [7:0]  buf_r [`FL_SECTOR_BYTES];
	logic [7:0]  rdat_r;
	logic [16:0] rd_adr_r;
	logic        done_r;
	logic        tmo_r;
	logic        locked_r;
	logic        poll_r;
	logic        have_r;
	logic        tog_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic [7:0]  pos_r;
	logic [19:0] cnt_r;
	logic [19:0] wc_r;
	logic [19:0] pwr_r;

	// bus decode
	wire        acc       = wb_cyc_i & wb_stb_i & ~ack_r;
	wire        wr        = acc & wb_we_i;
	wire        hit_buf   = wb_adr_i[`FL_BUF_BIT] & (wb_adr_i[1:0] == 2'h0);
	wire        hit_ctrl  = wb_adr_i == `FL_REG_CTRL;
	wire        hit_addr  = wb_adr_i == `FL_REG_ADDR;
	wire        hit_wdat  = wb_adr_i == `FL_REG_WDATA;
	wire        hit_stat  = wb_adr_i == `FL_REG_STAT;
	wire [31:0] wm        = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] addr_wr   = ({15'h0000, adr_r} & ~wm) | (wb_dat_i & wm);
	wire [6:0]  buf_idx   = wb_adr_i[8:2];
	wire        pwr_ok    = pwr_r == 20'(POWER_CYC);
	wire        busy      = st_r != flash_host_pkg::ST_IDLE;

	// command decode
	assign op_new = flash_host_pkg::op_type'(wb_dat_i[3:0]);
	wire op_legal  = (wb_dat_i[3:0] != 4'h0) && (wb_dat_i[3:0] <= 4'ha);
	wire new_rd    = (op_new == flash_host_pkg::OP_READ) || (op_new == flash_host_pkg::OP_LOCK_STAT);
	wire new_guard = wb_sel_i[1] & wb_dat_i[`FL_CTRL_GUARD];
	// programming-type orders wait for the supply delay
	wire start     = wr & hit_ctrl & wb_sel_i[0] & ~busy & op_legal & (new_rd | pwr_ok);
	wire new_long  = (op_new == flash_host_pkg::OP_GUARD_OFF) || (op_new == flash_host_pkg::OP_ERASE)
			|| (op_new == flash_host_pkg::OP_LOCK);
	wire new_data  = (op_new == flash_host_pkg::OP_WRITE) || (op_new == flash_host_pkg::OP_PROGRAM);
	// data orders take the 3-byte guard prefix only when asked
	wire [7:0] pos_start = new_long ? 8'h00 : (new_data & ~new_guard) ? `FL_POS_CMD_END : `FL_POS_SHORT;
	// block select comes from the data register, since the order bits own ctrl bit 0
	wire [16:0] lock_adr = wdat_r[`FL_LOCK_HI_SEL] ? 17'(`FL_ADR_LOCK_HI) : 17'(`FL_ADR_LOCK_LO);

	// sequence decode on the running order
	wire is_prog  = op_r == flash_host_pkg::OP_PROGRAM;
	// a program order always loads the whole sector, never a part
	wire [7:0] pos_end = is_prog ? 8'(`FL_POS_CMD_END + `FL_SECTOR_BYTES) :
			((op_r == flash_host_pkg::OP_WRITE) || (op_r == flash_host_pkg::OP_LOCK)) ?
			`FL_POS_CMD_END + 8'h01 : `FL_POS_CMD_END;
	wire need_poll = (op_r != flash_host_pkg::OP_ID_ENTER) && (op_r != flash_host_pkg::OP_ID_EXIT);
	wire [7:0] load_j = pos_r - `FL_POS_CMD_END;
	wire [7:0] code =
			(op_r == flash_host_pkg::OP_GUARD_OFF) ? `FL_CODE_UNGUARD :
			(op_r == flash_host_pkg::OP_ERASE)     ? `FL_CODE_ERASE :
			(op_r == flash_host_pkg::OP_ID_ENTER)  ? `FL_CODE_ID_IN :
			(op_r == flash_host_pkg::OP_ID_EXIT)   ? `FL_CODE_ID_OUT :
			(op_r == flash_host_pkg::OP_LOCK)      ? `FL_CODE_LOCK :
			`FL_CODE_GUARD;
	wire u1 = (pos_r == 8'h00) || (pos_r == 8'h03);
	wire u2 = (pos_r == 8'h01) || (pos_r == 8'h04);
	wire in_cmd = pos_r < `FL_POS_CMD_END;
	// sector bits stay those of the address register for every data load
	wire [16:0] cur_adr = u1 ? `FL_SEQ_ADR1 : u2 ? `FL_SEQ_ADR2 : in_cmd ? `FL_SEQ_ADR1 :
			is_prog ? {adr_r[16:7], load_j[6:0]} : adr_r;
	wire [7:0]  cur_dat = u1 ? `FL_SEQ_DAT1 : u2 ? `FL_SEQ_DAT2 : (pos_r == 8'h02) ? `FL_SEQ_LONG :
			in_cmd ? code : is_prog ? buf_r[load_j[6:0]] : wdat_r;
	wire last_load = (pos_r + 8'h01) == pos_end;

	// phase timing
	wire [19:0] lim = (st_r == flash_host_pkg::ST_LOW)     ? 20'(`FL_WP_CYC - 1) :
			(st_r == flash_host_pkg::ST_HIGH)    ? 20'(`FL_WPH_CYC - 1) :
			(st_r == flash_host_pkg::ST_ENDWAIT) ? 20'(LOAD_END_CYC - 1) :
			(st_r == flash_host_pkg::ST_READ)    ? 20'(`FL_RD_CYC - 1) : 20'h00000;
	wire phase_end = cnt_r == lim;
	// done once data_pin_6 reads the same twice running
	wire settled = have_r & (rdat_r[6] == tog_r);
	wire wc_over = wc_r >= 20'(WC_CYC);

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			flash_host_pkg::ST_IDLE: begin
				if (start)
					st_nxt = new_rd ? flash_host_pkg::ST_READ : flash_host_pkg::ST_SETUP;
			end
			flash_host_pkg::ST_SETUP: st_nxt = flash_host_pkg::ST_LOW;
			flash_host_pkg::ST_LOW: begin
				if (phase_end)
					st_nxt = flash_host_pkg::ST_HIGH;
			end
			flash_host_pkg::ST_HIGH: begin
				if (phase_end && !last_load)
					st_nxt = flash_host_pkg::ST_SETUP;
				else if (phase_end)
					st_nxt = need_poll ? flash_host_pkg::ST_ENDWAIT : flash_host_pkg::ST_IDLE;
			end
			flash_host_pkg::ST_ENDWAIT: begin
				if (phase_end)
					st_nxt = flash_host_pkg::ST_READ;
			end
			flash_host_pkg::ST_READ: begin
				if (phase_end)
					st_nxt = flash_host_pkg::ST_RGAP;
			end
			flash_host_pkg::ST_RGAP: begin
				st_nxt = (!poll_r || settled || wc_over) ? flash_host_pkg::ST_IDLE : flash_host_pkg::ST_READ;
			end
		endcase
	end

	// pin decode: strobe low with chip select low and read enable high
	assign s.ce_n = ~((st_r == flash_host_pkg::ST_SETUP) | (st_r == flash_host_pkg::ST_LOW)
			| (st_r == flash_host_pkg::ST_HIGH) | (st_r == flash_host_pkg::ST_READ));
	assign s.oe_n = st_r != flash_host_pkg::ST_READ;
	assign s.we_n = st_r != flash_host_pkg::ST_LOW;
	// data driven only while read enable is high, so never against the flash
	assign s.doe  = (st_r == flash_host_pkg::ST_SETUP) | (st_r == flash_host_pkg::ST_LOW)
			| (st_r == flash_host_pkg::ST_HIGH);
	assign s.adr  = s.doe ? cur_adr : rd_adr_r;
	assign s.dout = cur_dat;

	flash_pin_drv pins (
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.s              (s.pin),
		.flash_adr_o    (flash_adr_o),
		.flash_ce_n_o   (flash_ce_n_o),
		.flash_oe_n_o   (flash_oe_n_o),
		.flash_we_n_o   (flash_we_n_o),
		.flash_dat_o    (flash_dat_o),
		.flash_dat_oe_o (flash_dat_oe_o),
		.flash_dat_i    (flash_dat_i)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r  <= flash_host_pkg::ST_IDLE;
			cnt_r <= 20'h00000;
			pwr_r <= 20'h00000;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= (st_nxt != st_r) ? 20'h00000 : cnt_r + 20'h00001;
			if (!pwr_ok)
				pwr_r <= pwr_r + 20'h00001;
		end
	end

	// sequence position and poll bookkeeping
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op_r     <= flash_host_pkg::OP_NONE;
			pos_r    <= 8'h00;
			poll_r   <= 1'b0;
			have_r   <= 1'b0;
			tog_r    <= 1'b0;
			wc_r     <= 20'h00000;
			rd_adr_r <= 17'h00000;
		end else if (start) begin
			op_r     <= op_new;
			pos_r    <= pos_start;
			poll_r   <= 1'b0;
			have_r   <= 1'b0;
			rd_adr_r <= (op_new == flash_host_pkg::OP_LOCK_STAT) ? lock_adr : adr_r;
		end else begin
			if (st_r == flash_host_pkg::ST_HIGH && phase_end) begin
				pos_r    <= pos_r + 8'h01;
				rd_adr_r <= cur_adr;  // poll the last loaded byte
			end
			if (st_r == flash_host_pkg::ST_ENDWAIT) begin
				poll_r <= 1'b1;
			end
			wc_r <= (st_r == flash_host_pkg::ST_HIGH) ? 20'h00000 : wc_r + 20'h00001;
			if (st_r == flash_host_pkg::ST_RGAP) begin
				tog_r  <= rdat_r[6];
				have_r <= 1'b1;
			end
		end
	end

	// results
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r   <= 8'h00;
			done_r   <= 1'b0;
			tmo_r    <= 1'b0;
			locked_r <= 1'b0;
		end else begin
			if (st_r == flash_host_pkg::ST_READ && phase_end)
				rdat_r <= s.din;
			if (start) begin
				done_r <= 1'b0;
				tmo_r  <= 1'b0;
			end else if (st_r == flash_host_pkg::ST_RGAP && st_nxt == flash_host_pkg::ST_IDLE) begin
				done_r <= ~poll_r | settled;  // true data now valid
				tmo_r  <= poll_r & ~settled;
				if (op_r == flash_host_pkg::OP_LOCK_STAT)
					locked_r <= rdat_r == `FL_LOCKED;
			end
		end
	end

	// software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adr_r   <= 17'h00000;
			wdat_r  <= 8'h00;
			guard_r <= 1'b0;
		end else begin
			if (wr && hit_addr)
				adr_r <= addr_wr[16:0];
			if (wr && hit_wdat && wb_sel_i[0])
				wdat_r <= wb_dat_i[7:0];
			if (start)
				guard_r <= new_guard;
		end
	end

	for (genvar i = 0; i < `FL_SECTOR_BYTES; i++) begin : g_buf
		always_ff @(posedge clk_i) begin
			if (wr && hit_buf && wb_sel_i[0] && buf_idx == 7'(i))
				buf_r[i] <= wb_dat_i[7:0];
		end
	end

	wire [31:0] stat_word = {16'h0000, rdat_r, 2'h0, guard_r, locked_r, pwr_ok, tmo_r, done_r, busy};
	wire [31:0] rd_mux = hit_ctrl ? {28'h0000000, op_r} :
			hit_addr ? {15'h0000, adr_r} :
			hit_wdat ? {24'h000000, wdat_r} :
			hit_stat ? stat_word :
			hit_buf  ? {24'h000000, buf_r[buf_idx]} : 32'h00000000;

	// unmapped addresses still acknowledge, reading zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= acc;
			dat_r <= rd_mux;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
endmodule

/* tb/flash_host_ctl_monitor.sv */
// port checker for the flash host controller
`timescale 1ns/10ps
module flash_host_ctl_monitor #(
	parameter int unsigned POWER_CYC = 50
) (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// wishbone
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	// flash pins
	input wire logic [16:0] flash_adr_o,
	input wire logic        flash_ce_n_o,
	input wire logic        flash_oe_n_o,
	input wire logic        flash_we_n_o,
	input wire logic [7:0]  flash_dat_o,
	input wire logic        flash_dat_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// saturating, so a long run never wraps it
	logic [31:0] up_r;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			up_r <= '0;
		else if (up_r < POWER_CYC)
			up_r <= up_r + 32'h1;
	end
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	load_pins_a: assert property (!flash_we_n_o |-> flash_oe_n_o && !flash_ce_n_o && flash_dat_oe_o)
		else $error("byte load with bad strobes");
	read_quiet_a: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_dat_oe_o)
		else $error("host drives during read");
	strobe_width_a: assert property ($fell(flash_we_n_o) |-> (!flash_we_n_o) [*8])
		else $error("write strobe too short");
	strobe_high_a: assert property ($rose(flash_we_n_o) |-> flash_we_n_o [*8])
		else $error("write strobe high too short");
	load_stable_a: assert property (!flash_we_n_o |=> $stable(flash_adr_o) && $stable(flash_dat_o))
		else $error("address or data moved in load");
	power_wait_a: assert property (up_r < POWER_CYC |-> flash_we_n_o)
		else $error("load before power wait");
	byte_gap_a: assert property ($rose(flash_we_n_o) |-> ##[1:20] (!flash_we_n_o || flash_ce_n_o))
		else $error("byte gap too long");
	cover property ($fell(flash_we_n_o));
	cover property (!flash_oe_n_o && !flash_ce_n_o);
	cover property (wb_ack_o);
endmodule
bind flash_host_ctl flash_host_ctl_monitor #(.POWER_CYC(POWER_CYC)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_adr_o(flash_adr_o),
	.flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
	.flash_dat_o(flash_dat_o), .flash_dat_oe_o(flash_dat_oe_o));

/* tb/flash_dev_model.sv */
// behavioural sector flash seen from its pins
`timescale 1ns/10ps
`include "flash_host_params.svh"
module flash_dev_model #(
	parameter int         LOAD_WIN = 15,
	parameter int         BUSY_CYC = 60,
	parameter int         PWR_CYC  = 40,
	parameter logic [7:0] MFR_CODE = 8'h5c, // arbitrary value
	parameter logic [7:0] DEV_CODE = 8'h3a  // arbitrary value
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// flash pins
	input  wire logic [16:0] adr_i,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic [7:0]  dat_i,
	output logic      [7:0]  dat_o
);
	logic [7:0]  mem [0:131071];
	logic [16:0] qa [0:139];
	logic [7:0]  qd [0:139];
	logic [16:0] la;
	logic [7:0]  last, rd, ld;
	logic        we_q = 1, oe_q = 1, tog = 0, guard = 0, id = 0, lk_lo = 0, lk_hi = 0;
	int          n = 0, n_last = 0, idle = 0, busy = 0, pwr = 0;
	wire         rd_en = !ce_n_i && !oe_n_i;
	initial
		for (int i = 0; i < 131072; i++)
			mem[i] = 8'hff;
	function automatic logic pre();
		return qa[0] == `FL_SEQ_ADR1 && qd[0] == `FL_SEQ_DAT1 && qa[1] == `FL_SEQ_ADR2 && qd[1] == `FL_SEQ_DAT2;
	endfunction
	function automatic logic blk(input logic [16:0] a);
		return (lk_lo && a[16:13] == 4'h0) || (lk_hi && a[16:13] == 4'hf);
	endfunction
	always_comb begin
		if (id && (adr_i == 17'h00002 || adr_i == 17'h1fff2))
			rd = (adr_i[16] ? lk_hi : lk_lo) ? 8'hff : 8'hfe;
		else if (id)
			rd = adr_i[0] ? DEV_CODE : MFR_CODE;
		else if (busy > 0)
			rd = {~ld[7], tog, mem[adr_i][5:0]};
		else
			rd = mem[adr_i];
	end
	// no pull on the bus: a released line shows the inverse, not a held value
	assign dat_o = rd_en ? rd : ~last;
	task automatic finish_load();
		int s;
		s = 0;
		busy = BUSY_CYC;
		ld = qd[n - 1];
		if (pre() && n >= 7 && qd[2] == `FL_SEQ_LONG && qd[5] == `FL_CODE_LOCK) begin
			lk_lo |= qa[6][16:13] == 4'h0;
			lk_hi |= qa[6][16:13] == 4'hf;
		end else if (pre() && n >= 6 && qd[2] == `FL_SEQ_LONG) begin
			if (qd[5] == `FL_CODE_UNGUARD)
				guard = 0;
			if (qd[5] == `FL_CODE_ERASE && !lk_lo && !lk_hi)
				for (int i = 0; i < 131072; i++)
					mem[i] = 8'hff;
		end else begin
			if (pre() && n >= 3 && qd[2] == `FL_CODE_GUARD) begin
				guard = 1;
				s = 3;
			end else if (guard)
				s = n;
			if (s < n && !blk(qa[s]))
				for (int i = 0; i < 128; i++)
					mem[{qa[s][16:7], 7'(i)}] = 8'hff;
			for (int i = s; i < n; i++)
				if (!blk(qa[i]))
					mem[qa[i]] = qd[i];
		end
		n_last = n;
		n = 0;
	endtask
	always @(posedge clk_i) begin
		we_q <= we_n_i;
		oe_q <= oe_n_i;
		if (rd_en)
			last <= rd;
		if (oe_q && !oe_n_i && !ce_n_i)
			tog <= ~tog;
		if (busy > 0)
			busy = busy - 1;
		if (rst_i)
			pwr = 0;
		else if (pwr < PWR_CYC)
			pwr = pwr + 1;
		if (we_q && !we_n_i && !ce_n_i && oe_n_i)
			la <= adr_i;
		if (!we_q && we_n_i && !ce_n_i && oe_n_i && pwr >= PWR_CYC && busy == 0) begin
			qa[n] = la;
			qd[n] = dat_i;
			n++;
			if (n == 3 && pre() && (qd[2] == `FL_CODE_ID_IN || qd[2] == `FL_CODE_ID_OUT)) begin
				id = qd[2] == `FL_CODE_ID_IN;
				n = 0;
			end
		end
		if (!we_n_i)
			idle = 0;
		else if (n > 0) begin
			idle++;
			if (idle > LOAD_WIN)
				finish_load();
		end
	end
endmodule

/* tb/tb.sv */
// self-checking bench for the flash host controller
`timescale 1ns/10ps
`include "flash_host_params.svh"
module tb;
	localparam logic [7:0] MFR = 8'h5c; // arbitrary value
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [9:0]  adr = '0;
	logic [31:0] wdat = '0, rdat, q;
	logic        ack, ce_n, oe_n, we_n, doe;
	logic [16:0] fadr;
	logic [7:0]  fdo, fdi, mdo;
	int          error_cnt = 0, tests_run = 0, cyc_cnt = 0;
	assign fdi = doe ? fdo : mdo;
	flash_host_ctl #(.LOAD_END_CYC(20), .WC_CYC(400), .POWER_CYC(50)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .flash_adr_o(fadr), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
		.flash_we_n_o(we_n), .flash_dat_o(fdo), .flash_dat_oe_o(doe), .flash_dat_i(fdi));
	flash_dev_model #(.MFR_CODE(MFR)) u_mod (.clk_i(clk_i), .rst_i(rst_i), .adr_i(fadr), .ce_n_i(ce_n),
		.oe_n_i(oe_n), .we_n_i(we_n), .dat_i(fdi), .dat_o(mdo));
	initial
		forever #5 clk_i = ~clk_i;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20)
			check(32'h0, 32'h1);
	endtask
	// runs one operation and polls status until it is idle
	task automatic op(input logic [3:0] c, input logic g, input logic [16:0] a, input logic [7:0] d);
		int k;
		k = 0;
		wb(1'b1, `FL_REG_ADDR, {15'h0, a});
		wb(1'b1, `FL_REG_WDATA, {24'h0, d});
		wb(1'b1, `FL_REG_CTRL, {23'h0, g, 4'h0, c});
		do begin
			wb(1'b0, `FL_REG_STAT, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 2000);
		check({30'h0, q[2], q[0]}, 32'h0);
	endtask
	task automatic rd_chk(input logic [16:0] a, input logic [7:0] d);
		op(4'h1, 1'b0, a, 8'h0);
		check(32'(q[15:8]), 32'(d));
	endtask
	task automatic lock_chk(input logic hi, input logic exp);
		op(4'ha, 1'b0, 17'h0, {7'h0, hi});
		check(32'(q[4]), 32'(exp));
	endtask
	task automatic s_power();
		wb(1'b0, `FL_REG_STAT, 32'h0);
		check(32'(q[3]), 32'h0);
		op(4'h2, 1'b0, 17'h00100, 8'h11);
		check(32'(q[1]), 32'h0);
		repeat (60) @(posedge clk_i);
		wb(1'b0, `FL_REG_STAT, 32'h0);
		check(32'(q[3]), 32'h1);
	endtask
	task automatic s_write();
		op(4'h2, 1'b0, 17'h00100, 8'h5a);
		check(32'(q[1]), 32'h1);
		rd_chk(17'h00100, 8'h5a);
	endtask
	task automatic s_sector();
		for (int i = 0; i < 128; i++)
			wb(1'b1, 10'h200 + 10'(i * 4), 32'(8'(i) ^ 8'h3c));
		op(4'h3, 1'b0, 17'h00400, 8'h0);
		check(32'(u_mod.n_last), 32'd128);
		rd_chk(17'h00400, 8'h3c);
		rd_chk(17'h0047f, 8'h43);
	endtask
	task automatic s_guard();
		op(4'h4, 1'b0, 17'h0, 8'h0);
		check(32'(q[1]), 32'h1);
		op(4'h2, 1'b0, 17'h00100, 8'h11);
		rd_chk(17'h00100, 8'h5a);
		op(4'h2, 1'b1, 17'h00100, 8'h22);
		check(32'(q[5]), 32'h1);
		rd_chk(17'h00100, 8'h22);
		op(4'h5, 1'b0, 17'h0, 8'h0);
		op(4'h2, 1'b0, 17'h00100, 8'h33);
		rd_chk(17'h00100, 8'h33);
	endtask
	task automatic s_lock();
		op(4'h6, 1'b0, 17'h0, 8'h0);
		rd_chk(17'h00100, 8'hff);
		op(4'h2, 1'b0, 17'h00010, 8'h77);
		op(4'h2, 1'b0, 17'h04000, 8'h44);
		op(4'h7, 1'b0, 17'h0, 8'h0);
		rd_chk(17'h00000, MFR);
		lock_chk(1'b0, 1'b0);
		op(4'h8, 1'b0, 17'h0, 8'h0);
		op(4'h9, 1'b0, 17'h00000, 8'h00);
		op(4'h7, 1'b0, 17'h0, 8'h0);
		lock_chk(1'b0, 1'b1);
		lock_chk(1'b1, 1'b0);
		op(4'h8, 1'b0, 17'h0, 8'h0);
		op(4'h2, 1'b0, 17'h00010, 8'h99);
		rd_chk(17'h00010, 8'h77);
		op(4'h2, 1'b0, 17'h04000, 8'h55);
		rd_chk(17'h04000, 8'h55);
		op(4'h6, 1'b0, 17'h0, 8'h0);
		rd_chk(17'h04000, 8'h55);
	endtask
	task automatic s_unmapped();
		wb(1'b1, 10'h100, 32'h0000_beef);
		wb(1'b0, 10'h100, 32'h0);
		check(q, 32'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		s_power();
		s_write();
		s_sector();
		s_guard();
		s_lock();
		s_unmapped();
		conclude();
	end
	// the whole sequence needs well under half of this
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			error_cnt++;
			conclude();
		end
	end
endmodule
